// ### zxa_unit.sv
/*
  zxa_unit: decode and datapath for halfword extend-add, halfword extend, byte extend.
  assumes the register file supplies both operands in the cycle of instr_valid and
  takes one write per cycle from wr_en/wr_idx/wr_data; flags come from the core.
*/
//
// Operation
// - halfword form rotates second operand, keeps low 16 bits, adds first operand.
// - rotation field 00/01/10/11 selects rotate right by 0/8/16/24, before masking.
// - execute and write destination only when condition in bits 31:28 passes.
// - first operand field 1111 turns the add form into plain halfword extend.
// - program counter as destination or second operand gives undefined result.
// - byte form zero-extends an 8-bit value of rotated source, no first operand.
// - byte result is rotated source masked to low eight bits.
// - halfword alias writes rotated source masked to low sixteen bits.
`timescale 1ns/100ps
module zxa_unit (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [zxa_pkg::DATA_W-1:0] instr_word,
  input wire logic [3:0] flags_nzcv,
  input wire logic [zxa_pkg::DATA_W-1:0] first_operand_reg,
  input wire logic [zxa_pkg::DATA_W-1:0] second_operand_reg,
  output logic wr_en,
  output logic [zxa_pkg::REG_IDX_W-1:0] wr_idx,
  output logic [zxa_pkg::DATA_W-1:0] wr_data,
  output logic unknown_instr,
  output logic pc_hazard
);
  import zxa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic [3:0] cond_f;
  logic [1:0] rot_f;
  logic [3:0] rn_f;
  logic n_f, z_f, c_f, v_f;
  logic cond_pass;
  zxa_op_t op;

  assign cond_f = instr_word[COND_HI:COND_LO];
  assign rot_f = instr_word[ROT_HI:ROT_LO];
  assign rn_f = instr_word[RN_HI:RN_LO];
  assign {n_f, z_f, c_f, v_f} = flags_nzcv;

  always_comb begin
    case (cond_f)
      CC_EQ: cond_pass = z_f;
      CC_NE: cond_pass = !z_f;
      CC_CS: cond_pass = c_f;
      CC_CC: cond_pass = !c_f;
      CC_MI: cond_pass = n_f;
      CC_PL: cond_pass = !n_f;
      CC_VS: cond_pass = v_f;
      CC_VC: cond_pass = !v_f;
      CC_HI: cond_pass = c_f && !z_f;
      CC_LS: cond_pass = !c_f || z_f;
      CC_GE: cond_pass = (n_f == v_f);
      CC_LT: cond_pass = (n_f != v_f);
      CC_GT: cond_pass = !z_f && (n_f == v_f);
      CC_LE: cond_pass = z_f || (n_f != v_f);
      CC_ALWAYS: cond_pass = 1'b1;
      default: cond_pass = 1'b0; // unconditional space is not ours
    endcase
  end

  // bits 9:8 are not checked; nonzero values are tolerated, not trapped
  always_comb begin
    op = ZXA_NONE;
    if (instr_word[SUB_HI:SUB_LO] == SUB_EXT) begin
      if (instr_word[OPC_HI:OPC_LO] == OPC_HALF) begin
        op = (rn_f == RN_NONE) ? ZXA_HALF : ZXA_HALF_ADD;
      end else if (instr_word[OPC_HI:OPC_LO] == OPC_BYTE && rn_f == RN_NONE) begin
        op = ZXA_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath
  logic [DATA_W-1:0] rotated;
  logic [DATA_W-1:0] result;

  always_comb begin
    case (rot_f)
      2'b00: rotated = second_operand_reg;
      2'b01: rotated = {second_operand_reg[7:0], second_operand_reg[31:8]};
      2'b10: rotated = {second_operand_reg[15:0], second_operand_reg[31:16]};
      default: rotated = {second_operand_reg[23:0], second_operand_reg[31:24]};
    endcase
  end

  always_comb begin
    case (op)
      ZXA_HALF_ADD: result = first_operand_reg + (rotated & MASK_HALF);
      ZXA_HALF: result = rotated & MASK_HALF;
      ZXA_BYTE: result = rotated & MASK_BYTE;
      default: result = RESET_DATA;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write-back registers
  logic wr_en_next, unknown_next, pc_hazard_next;
  logic [REG_IDX_W-1:0] wr_idx_next;
  logic [DATA_W-1:0] wr_data_next;

  always_comb begin
    wr_en_next = instr_valid && (op != ZXA_NONE) && cond_pass;
    wr_idx_next = instr_word[RD_HI:RD_LO];
    wr_data_next = result;
    unknown_next = instr_valid && (op == ZXA_NONE);
    // pc as rd or rm: result is still written but carries no guarantee
    pc_hazard_next = instr_valid && (op != ZXA_NONE) &&
                     (instr_word[RD_HI:RD_LO] == PC_IDX ||
                      instr_word[RM_HI:RM_LO] == PC_IDX);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_en <= 1'b0;
      wr_idx <= '0;
      wr_data <= RESET_DATA;
      unknown_instr <= 1'b0;
      pc_hazard <= 1'b0;
    end else begin
      wr_en <= wr_en_next;
      wr_idx <= wr_idx_next;
      wr_data <= wr_data_next;
      unknown_instr <= unknown_next;
      pc_hazard <= pc_hazard_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cond_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && !cond_pass) |=> !wr_en;
  endproperty
  a_cond_gate: assert property (p_cond_gate) else $error("write despite failed condition");

  property p_half_add;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && cond_pass && instr_word[SUB_HI:SUB_LO] == SUB_EXT &&
     instr_word[OPC_HI:OPC_LO] == OPC_HALF && rn_f != RN_NONE && rot_f == 2'b00)
    |=> wr_en && wr_data == $past(first_operand_reg) + {16'h0000, $past(second_operand_reg[15:0])};
  endproperty
  a_half_add: assert property (p_half_add) else $error("halfword add result wrong");

  property p_rot8;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && cond_pass && op == ZXA_BYTE && rot_f == 2'b01)
    |=> wr_data == {24'h00_0000, $past(second_operand_reg[15:8])};
  endproperty
  a_rot8: assert property (p_rot8) else $error("rotate by 8 wrong");

  property p_rot24;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && cond_pass && op == ZXA_HALF && rot_f == 2'b11)
    |=> wr_data == {16'h0000, $past(second_operand_reg[7:0]), $past(second_operand_reg[31:24])};
  endproperty
  a_rot24: assert property (p_rot24) else $error("rotate by 24 wrong");

  property p_alias;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && cond_pass && instr_word[OPC_HI:OPC_LO] == OPC_HALF &&
     instr_word[SUB_HI:SUB_LO] == SUB_EXT && rn_f == RN_NONE)
    |=> wr_en && wr_data[31:16] == 16'h0000;
  endproperty
  a_alias: assert property (p_alias) else $error("halfword alias added operand");

  property p_byte_mask;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && cond_pass && op == ZXA_BYTE) |=> wr_en && wr_data[31:8] == 24'h00_0000;
  endproperty
  a_byte_mask: assert property (p_byte_mask) else $error("byte result upper bits set");

  property p_byte_need_rn;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && instr_word[OPC_HI:OPC_LO] == OPC_BYTE && rn_f != RN_NONE) |=> !wr_en;
  endproperty
  a_byte_need_rn: assert property (p_byte_need_rn) else $error("bad byte form accepted");

  property p_dest_idx;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_en |-> wr_idx == $past(instr_word[RD_HI:RD_LO]) && $past(instr_valid);
  endproperty
  a_dest_idx: assert property (p_dest_idx) else $error("wrong destination index");

  property p_pc_flag;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && op != ZXA_NONE && instr_word[RM_HI:RM_LO] == PC_IDX) |=> pc_hazard;
  endproperty
  a_pc_flag: assert property (p_pc_flag) else $error("pc hazard not flagged");

  property p_pc_rd;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && op != ZXA_NONE && instr_word[RD_HI:RD_LO] == PC_IDX) |=> pc_hazard;
  endproperty
  a_pc_rd: assert property (p_pc_rd) else $error("pc destination not flagged");

  property p_rot16;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && cond_pass && op == ZXA_HALF && rot_f == 2'b10)
    |=> wr_en && wr_data == {16'h0000, $past(second_operand_reg[31:16])};
  endproperty
  a_rot16: assert property (p_rot16) else $error("rotate by 16 wrong");

  property p_byte_rot0;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && cond_pass && op == ZXA_BYTE && rot_f == 2'b00)
    |=> wr_en && wr_data == {24'h00_0000, $past(second_operand_reg[7:0])};
  endproperty
  a_byte_rot0: assert property (p_byte_rot0) else $error("byte extract wrong");

  // unknown words must never reach the register file
  property p_unknown;
    @(posedge clk_sys) disable iff (!reset_n)
    (instr_valid && op == ZXA_NONE) |=> unknown_instr && !wr_en;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown word not refused");

  property p_idle;
    @(posedge clk_sys) disable iff (!reset_n)
    !instr_valid |=> !wr_en && !unknown_instr && !pc_hazard;
  endproperty
  a_idle: assert property (p_idle) else $error("output pulse without instruction");
endmodule

// ### zxa_pkg.sv
/*
  zxa_pkg: encodings, field positions and condition codes for the zero-extend unit.
  assumes a 32-bit instruction word and a 16-entry register file outside.
*/
package zxa_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned COND_HI = 31;
  localparam int unsigned COND_LO = 28;
  localparam int unsigned OPC_HI = 27;
  localparam int unsigned OPC_LO = 20;
  localparam int unsigned RN_HI = 19;
  localparam int unsigned RN_LO = 16;
  localparam int unsigned RD_HI = 15;
  localparam int unsigned RD_LO = 12;
  localparam int unsigned ROT_HI = 11;
  localparam int unsigned ROT_LO = 10;
  localparam int unsigned SBZ_HI = 9;
  localparam int unsigned SBZ_LO = 8;
  localparam int unsigned SUB_HI = 7;
  localparam int unsigned SUB_LO = 4;
  localparam int unsigned RM_HI = 3;
  localparam int unsigned RM_LO = 0;
  localparam logic [7:0] OPC_HALF = 8'h6f;
  localparam logic [7:0] OPC_BYTE = 8'h6e;
  localparam logic [3:0] SUB_EXT = 4'h7;
  localparam logic [3:0] RN_NONE = 4'hf;
  localparam logic [3:0] PC_IDX = 4'hf;
  localparam logic [31:0] MASK_HALF = 32'h0000_ffff;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
  localparam logic [31:0] RESET_DATA = 32'h0000_0000;
  // condition codes, flags n z c v
  localparam logic [3:0] CC_EQ = 4'h0;
  localparam logic [3:0] CC_NE = 4'h1;
  localparam logic [3:0] CC_CS = 4'h2;
  localparam logic [3:0] CC_CC = 4'h3;
  localparam logic [3:0] CC_MI = 4'h4;
  localparam logic [3:0] CC_PL = 4'h5;
  localparam logic [3:0] CC_VS = 4'h6;
  localparam logic [3:0] CC_VC = 4'h7;
  localparam logic [3:0] CC_HI = 4'h8;
  localparam logic [3:0] CC_LS = 4'h9;
  localparam logic [3:0] CC_GE = 4'ha;
  localparam logic [3:0] CC_LT = 4'hb;
  localparam logic [3:0] CC_GT = 4'hc;
  localparam logic [3:0] CC_LE = 4'hd;
  localparam logic [3:0] CC_ALWAYS = 4'he;
  typedef enum {ZXA_NONE, ZXA_HALF_ADD, ZXA_HALF, ZXA_BYTE} zxa_op_t;
endpackage

// ### zxa_regfile.sv
/*
  zxa_regfile: register file partner for the zero-extend unit.
  assumes operand indices come straight from the instruction word; one write a cycle.
*/
`timescale 1ns/100ps
module zxa_regfile (
  input wire logic clk_sys,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_a,
  output logic [31:0] rd_b
);
  logic [31:0] regs [16];
  // distinct bytes everywhere so a wrong rotation shows
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 32'h8d3b_6a15 ^ (32'h0101_0101 * i);
    end
  end
  assign rd_a = regs[rd_a_idx];
  assign rd_b = regs[rd_b_idx];
  always @(posedge clk_sys) begin
    if (wr_en) begin
      regs[wr_idx] <= wr_data;
    end
  end
endmodule

// ### tb_zero_extend_add_unit.sv
/*
  tb_zero_extend_add_unit: directed bench for zxa_unit with a register file partner.
  assumes one-cycle registered answer; sources 2..6 are never written.
*/
`timescale 1ns/100ps
module tb_zero_extend_add_unit;
  import zxa_pkg::*;
  logic clk_sys = 0, reset_n = 0, instr_valid = 0;
  logic [31:0] instr_word = '0, a_val, b_val, wr_data;
  logic [3:0] flags_nzcv = '0, wr_idx;
  logic wr_en, unknown_instr, pc_hazard;
  int miscompares = 0, n_compared = 0, cycles = 0;
  zxa_unit dut (.clk_sys(clk_sys), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .flags_nzcv(flags_nzcv), .first_operand_reg(a_val),
    .second_operand_reg(b_val), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .unknown_instr(unknown_instr), .pc_hazard(pc_hazard));
  zxa_regfile partner (.clk_sys(clk_sys), .rd_a_idx(instr_word[19:16]),
    .rd_b_idx(instr_word[3:0]), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .rd_a(a_val), .rd_b(b_val));
  initial forever #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rv(input int i);
    return 32'h8d3b_6a15 ^ (32'h0101_0101 * i);
  endfunction
  function automatic logic [31:0] rotate_right_shift(input logic [31:0] v, input int r);
    return (v >> (8 * r)) | (v << (32 - 8 * r));
  endfunction
  function automatic logic [31:0] mk(input logic [3:0] c, input logic [7:0] op,
    input logic [3:0] n, d, input logic [1:0] rt, input logic [3:0] s, m);
    return {c, op, n, d, rt, 2'b00, s, m};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic outs(input logic [31:0] w, d, input logic en, unk, pc);
    chk("wr_en", en, wr_en);
    if (en) begin
      chk("wr_data", d, wr_data);
      chk("wr_idx", w[15:12], wr_idx);
    end
    chk("unknown_instr", unk, unknown_instr);
    chk("pc_hazard", pc, pc_hazard);
  endtask
  task automatic run(input logic [31:0] w, input logic en, input logic [31:0] d,
    input logic unk, pc);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    outs(w, d, en, unk, pc);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_forms();
    for (int r = 0; r < 4; r++) begin
      run(mk(CC_ALWAYS, OPC_HALF, 4'h2, 4'h1, r, SUB_EXT, 4'h3), 1, rv(2) + (rotate_right_shift(rv(3), r) & MASK_HALF), 0, 0);
      run(mk(CC_ALWAYS, OPC_HALF, RN_NONE, 4'h7, r, SUB_EXT, 4'h4), 1, rotate_right_shift(rv(4), r) & MASK_HALF, 0, 0);
      run(mk(CC_ALWAYS, OPC_BYTE, RN_NONE, 4'h7, r, SUB_EXT, 4'h5), 1, rotate_right_shift(rv(5), r) & MASK_BYTE, 0, 0);
    end
    $display("test forms done");
  endtask
  task automatic t_cond();
    flags_nzcv <= 4'b0000;
    run(mk(CC_EQ, OPC_HALF, 4'h2, 4'h1, 0, SUB_EXT, 4'h3), 0, 0, 0, 0);
    run(mk(4'hf, OPC_BYTE, RN_NONE, 4'h1, 0, SUB_EXT, 4'h3), 0, 0, 0, 0);
    flags_nzcv <= 4'b0100;
    run(mk(CC_EQ, OPC_BYTE, RN_NONE, 4'h1, 1, SUB_EXT, 4'h6), 1, rotate_right_shift(rv(6), 1) & MASK_BYTE, 0, 0);
    run(mk(CC_NE, OPC_HALF, 4'h2, 4'h1, 0, SUB_EXT, 4'h3), 0, 0, 0, 0);
    $display("test cond done");
  endtask
  task automatic t_decode();
    run(mk(CC_ALWAYS, OPC_HALF, 4'h2, 4'h1, 0, 4'h6, 4'h3), 0, 0, 1, 0);
    run(mk(CC_ALWAYS, OPC_BYTE, 4'h2, 4'h1, 0, SUB_EXT, 4'h3), 0, 0, 1, 0);
    run(mk(CC_ALWAYS, OPC_BYTE, RN_NONE, 4'h1, 2, SUB_EXT, 4'h3) | 32'h0000_0300, 1, rotate_right_shift(rv(3), 2) & MASK_BYTE, 0, 0);
    run(mk(CC_ALWAYS, OPC_HALF, 4'h2, PC_IDX, 0, SUB_EXT, 4'h3), 1, rv(2) + (rv(3) & MASK_HALF), 0, 1);
    run(mk(CC_ALWAYS, OPC_BYTE, RN_NONE, 4'h1, 0, SUB_EXT, PC_IDX), 1, (rv(2) + (rv(3) & MASK_HALF)) & MASK_BYTE, 0, 1);
    $display("test decode done");
  endtask
  task automatic t_b2b();
    logic [31:0] w1, w2;
    w1 = mk(CC_ALWAYS, OPC_HALF, 4'h6, 4'h1, 3, SUB_EXT, 4'h5);
    w2 = mk(CC_ALWAYS, OPC_BYTE, RN_NONE, 4'h7, 3, SUB_EXT, 4'h4);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w1;
    @(posedge clk_sys);
    instr_word <= w2;
    #1;
    outs(w1, rv(6) + (rotate_right_shift(rv(5), 3) & MASK_HALF), 1, 0, 0);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    outs(w2, rotate_right_shift(rv(4), 3) & MASK_BYTE, 1, 0, 0);
    @(posedge clk_sys);
    #1;
    chk("wr_en", 0, wr_en);
    $display("test b2b done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    // about 52 cycles expected; generous ceiling
    if (cycles == 1000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    chk("wr_en", 0, wr_en);
    reset_n <= 1'b1;
    t_forms();
    t_cond();
    t_decode();
    t_b2b();
    complete_run();
  end
endmodule
